// ---- aux_port_pkg.sv ----
// Shared constants for the auxiliary serial data port
package aux_port_pkg;
   // ---------------------------------------------------------------
   // Clocking
   // ---------------------------------------------------------------
   localparam int unsigned CLK_HZ        = 25_000_000;
   localparam int unsigned INT_BIT_HZ    = 1_000_000;
   localparam int unsigned DIV_HALF_INT  = CLK_HZ / (2 * INT_BIT_HZ);
   localparam int          DIV_W         = 8;
   localparam logic [7:0]  DIV_HALF      = DIV_HALF_INT[7:0] - 8'h01;
   localparam int unsigned EXT_CLK_MAX_HZ = 50_000_000;

   // ---------------------------------------------------------------
   // Field widths
   // ---------------------------------------------------------------
   localparam int SYM_W    = 4;
   localparam int SLOT_W   = 8;
   localparam int FRAME_W  = 10;
   localparam int MARK_N   = 4;
   localparam int WAVE_AW  = 8;
   localparam int AUX_W    = 16;
   localparam int SYNC_LW  = 4;

   // ---------------------------------------------------------------
   // Link sync vector positions
   // ---------------------------------------------------------------
   localparam int LNK_CLK  = 0;
   localparam int LNK_DAT  = 1;
   localparam int LNK_SYM  = 2;
   localparam int LNK_STB  = 3;

   // ---------------------------------------------------------------
   // Reset values and generator taps
   // ---------------------------------------------------------------
   localparam logic [8:0]  PRBS_SEED  = 9'h1ff;
   localparam int          PRBS_TAP_A = 8;
   localparam int          PRBS_TAP_B = 4;
   localparam logic [SYM_W-1:0]   SYM_ONE   = 4'h1;
   localparam logic [FRAME_W-1:0] FRAME_ONE = 10'h001;
   localparam logic [WAVE_AW-1:0] WAVE_ONE  = 8'h01;
endpackage

// ---- link_sync.sv ----
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module link_sync
   import aux_port_pkg::*;
#(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Asynchronous input and filtered level
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] level
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;
   logic [W-1:0] next_level;

   // Stage one feeds only stage two
   always_comb begin
      next_level = ((s2 ~^ s3) & s3) | ((s2 ^ s3) & level);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1    <= '0;
         s2    <= '0;
         s3    <= '0;
         level <= '0;
      end else begin
         s1    <= din;
         s2    <= s1;
         s3    <= s2;
         level <= next_level;
      end
   end
endmodule

// ---- marker_mem.sv ----
// Per-point marker flag store with registered read
`timescale 1ns/1ps
module marker_mem
   import aux_port_pkg::*;
(
   // Clock
   input  wire logic               clk,
   // Write port
   input  wire logic               wr_en,
   input  wire logic [WAVE_AW-1:0] wr_addr,
   input  wire logic [MARK_N-1:0]  wr_data,
   // Read port
   input  wire logic [WAVE_AW-1:0] rd_addr,
   output logic      [MARK_N-1:0]  rd_data
);
   logic [MARK_N-1:0] mem [0:(1<<WAVE_AW)-1];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule

// ---- aux_serial_port.sv ----
// Auxiliary serial data port: bit clock, data, sync, events, markers
`timescale 1ns/1ps
module aux_serial_port
   import aux_port_pkg::*;
(
   // Clock and reset
   input  wire logic                      clk,
   input  wire logic                      rstn,
   // Configuration
   input  wire logic                      ext_clk_sel,
   input  wire logic                      data_src_ext,
   input  wire logic                      gate_en,
   input  wire logic                      rt_mode,
   input  wire logic [SYM_W-1:0]          bits_per_sym,
   input  wire logic [SLOT_W-1:0]         slot_bits,
   input  wire logic [FRAME_W-1:0]        frame_bits,
   input  wire logic signed [SLOT_W:0]    event_offset,
   input  wire logic [MARK_N-1:0]         marker_rt_sel,
   input  wire logic [MARK_N-1:0]         marker_pol_neg,
   input  wire logic [MARK_N-1:0]         rt_marker,
   // Waveform marker load
   input  wire logic                      wave_wr_en,
   input  wire logic [WAVE_AW-1:0]        wave_wr_addr,
   input  wire logic [MARK_N-1:0]         wave_wr_data,
   // Link inputs
   input  wire logic                      data_clk_in,
   input  wire logic                      data_in,
   input  wire logic                      sym_sync_in,
   input  wire logic                      aux_strobe,
   input  wire logic [AUX_W-1:0]          aux_in,
   // Link outputs
   output logic                           data_clk_out,
   output logic                           data_out,
   output logic                           sym_sync_out,
   output logic                           event_out,
   output logic                           data_en_n,
   output logic [MARK_N-1:0]              marker_out,
   // Auxiliary word
   output logic [AUX_W-1:0]               aux_word,
   output logic                           aux_word_valid
);
   // ---------------------------------------------------------------
   // Reset release
   // ---------------------------------------------------------------
   logic rst_meta;
   logic rst_n;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta <= 1'h0;
         rst_n    <= 1'h0;
      end else begin
         rst_meta <= 1'h1;
         rst_n    <= rst_meta;
      end
   end

   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   logic [SYNC_LW-1:0] lnk_lvl;
   logic [AUX_W-1:0]   aux_lvl;

   // Clock and data share equal latency, so the data level lines up with the edge
   link_sync #(.W(SYNC_LW)) u_lnk_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .din   ({aux_strobe, sym_sync_in, data_in, data_clk_in}),
      .level (lnk_lvl)
   );

   link_sync #(.W(AUX_W)) u_aux_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .din   (aux_in),
      .level (aux_lvl)
   );

   // ---------------------------------------------------------------
   // Event position within frame
   // ---------------------------------------------------------------
   function automatic logic [FRAME_W-1:0] event_pos(
      input logic signed [SLOT_W:0] off,
      input logic [SLOT_W-1:0]      slot,
      input logic [FRAME_W-1:0]     fbits
   );
      logic signed [FRAME_W+1:0] lim;
      logic signed [FRAME_W+1:0] o;
      logic signed [FRAME_W+1:0] p;
      lim = $signed({{(FRAME_W+2-SLOT_W){1'b0}}, slot});
      o   = (FRAME_W+2)'(off);
      if (o > lim) begin
         o = lim;
      end
      if (o < -lim) begin
         o = -lim;
      end
      p = (o < 0) ? o + $signed({2'b00, fbits}) : o;
      if (p >= $signed({2'b00, fbits})) begin
         p = '0;
      end
      return p[FRAME_W-1:0];
   endfunction

   // ---------------------------------------------------------------
   // Bit timing, data path and sync
   // ---------------------------------------------------------------
   logic                   clk_prev;
   logic                   stb_prev;
   logic [DIV_W-1:0]       div_cnt;
   logic [8:0]             prbs;
   logic                   ext_bit;
   logic                   ext_sym;
   logic [SYM_W-1:0]       sym_cnt;
   logic [FRAME_W-1:0]     bit_cnt;
   logic [WAVE_AW-1:0]     play_addr;

   logic                   next_clk_prev;
   logic                   next_stb_prev;
   logic [DIV_W-1:0]       next_div_cnt;
   logic                   next_data_clk_out;
   logic [8:0]             next_prbs;
   logic                   next_ext_bit;
   logic                   next_ext_sym;
   logic                   next_data_out;
   logic [SYM_W-1:0]       next_sym_cnt;
   logic                   next_sym_sync_out;
   logic [FRAME_W-1:0]     next_bit_cnt;
   logic                   next_event_out;
   logic                   next_data_en_n;
   logic [WAVE_AW-1:0]     next_play_addr;
   logic [AUX_W-1:0]       next_aux_word;
   logic                   next_aux_word_valid;

   logic ext_fall;
   logic ext_rise;
   logic div_tick;
   logic bit_tick;
   logic sym_edge;
   logic stb_rise;
   logic [SYM_W-1:0] sym_len;

   always_comb begin
      ext_fall = clk_prev & ~lnk_lvl[LNK_CLK];
      ext_rise = ~clk_prev & lnk_lvl[LNK_CLK];
      div_tick = (div_cnt == DIV_HALF);
      bit_tick = ext_clk_sel ? ext_rise : (div_tick & ~data_clk_out);
      stb_rise = ~stb_prev & lnk_lvl[LNK_STB];
      sym_len  = (bits_per_sym == '0) ? SYM_ONE : bits_per_sym;
      sym_edge = (sym_cnt == '0) | (ext_clk_sel & ext_sym);

      next_clk_prev       = lnk_lvl[LNK_CLK];
      next_stb_prev       = lnk_lvl[LNK_STB];
      next_div_cnt        = div_tick ? '0 : div_cnt + 8'h01;
      next_data_clk_out   = div_tick ? ~data_clk_out : data_clk_out;
      next_prbs           = prbs;
      next_ext_bit        = ext_bit;
      next_ext_sym        = ext_sym;
      next_data_out       = data_out;
      next_sym_cnt        = sym_cnt;
      next_sym_sync_out   = sym_sync_out;
      next_bit_cnt        = bit_cnt;
      next_event_out      = event_out;
      next_data_en_n      = data_en_n;
      next_play_addr      = play_addr;
      next_aux_word       = aux_word;
      next_aux_word_valid = 1'h0;

      if (ext_fall) begin
         next_ext_bit = lnk_lvl[LNK_DAT];
         next_ext_sym = lnk_lvl[LNK_SYM];
      end

      // Data, symbol sync, event and gate outputs advance at the start of a bit period
      if (bit_tick) begin
         next_prbs         = {prbs[7:0], prbs[PRBS_TAP_A] ^ prbs[PRBS_TAP_B]};
         next_data_out     = data_src_ext ? ext_bit : prbs[0];
         next_sym_sync_out = sym_edge;
         next_sym_cnt      = sym_edge ? sym_len - SYM_ONE : sym_cnt - SYM_ONE;
         next_bit_cnt      = (bit_cnt + FRAME_ONE >= frame_bits) ? '0 : bit_cnt + FRAME_ONE;
         next_event_out    = (bit_cnt == event_pos(event_offset, slot_bits, frame_bits));
         next_data_en_n    = ~(gate_en & data_src_ext
                               & (bit_cnt < {2'b00, slot_bits}));
         next_play_addr    = play_addr + WAVE_ONE;
      end

      if (rt_mode & stb_rise) begin
         next_aux_word       = aux_lvl;
         next_aux_word_valid = 1'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         clk_prev       <= 1'h0;
         stb_prev       <= 1'h0;
         div_cnt        <= '0;
         data_clk_out   <= 1'h0;
         prbs           <= PRBS_SEED;
         ext_bit        <= 1'h0;
         ext_sym        <= 1'h0;
         data_out       <= 1'h0;
         sym_cnt        <= '0;
         sym_sync_out   <= 1'h0;
         bit_cnt        <= '0;
         event_out      <= 1'h0;
         data_en_n      <= 1'h1;
         play_addr      <= '0;
         aux_word       <= '0;
         aux_word_valid <= 1'h0;
      end else begin
         clk_prev       <= next_clk_prev;
         stb_prev       <= next_stb_prev;
         div_cnt        <= next_div_cnt;
         data_clk_out   <= next_data_clk_out;
         prbs           <= next_prbs;
         ext_bit        <= next_ext_bit;
         ext_sym        <= next_ext_sym;
         data_out       <= next_data_out;
         sym_cnt        <= next_sym_cnt;
         sym_sync_out   <= next_sym_sync_out;
         bit_cnt        <= next_bit_cnt;
         event_out      <= next_event_out;
         data_en_n      <= next_data_en_n;
         play_addr      <= next_play_addr;
         aux_word       <= next_aux_word;
         aux_word_valid <= next_aux_word_valid;
      end
   end

   // ---------------------------------------------------------------
   // Markers
   // ---------------------------------------------------------------
   logic [MARK_N-1:0] wave_flags;

   // Flags lag the play address by one cycle, far below one bit period
   marker_mem u_marker_mem (
      .clk     (clk),
      .wr_en   (wave_wr_en),
      .wr_addr (wave_wr_addr),
      .wr_data (wave_wr_data),
      .rd_addr (play_addr),
      .rd_data (wave_flags)
   );

   genvar gi;
   generate
      for (gi = 0; gi < MARK_N; gi++) begin : g_mark
         logic next_mark;
         always_comb begin
            next_mark = (marker_rt_sel[gi] ? rt_marker[gi] : wave_flags[gi])
                        ^ marker_pol_neg[gi];
         end
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               marker_out[gi] <= 1'h0;
            end else begin
               marker_out[gi] <= next_mark;
            end
         end
         AST_MARKER: assert property (@(posedge clk) disable iff (!rst_n)
            1'b1 |=> marker_out[gi] == ($past(marker_rt_sel[gi]) ? $past(rt_marker[gi])
                                        : $past(wave_flags[gi])) ^ $past(marker_pol_neg[gi]))
            else $error("marker output mismatch");
         AST_POLARITY: assert property (@(posedge clk) disable iff (!rst_n)
            $rose(marker_pol_neg[gi]) && $stable(rt_marker[gi]) && marker_rt_sel[gi]
               && $stable(marker_rt_sel[gi]) |=> $changed(marker_out[gi]))
            else $error("polarity change not seen on marker");
      end
   endgenerate

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   AST_CAPTURE: assert property (@(posedge clk) disable iff (!rst_n)
      ext_fall |=> ext_bit == $past(lnk_lvl[LNK_DAT]) && ext_sym == $past(lnk_lvl[LNK_SYM]))
      else $error("input not captured on falling edge");
   AST_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
      !ext_fall |=> $stable(ext_bit))
      else $error("captured bit moved without falling edge");
   AST_DATA_SRC: assert property (@(posedge clk) disable iff (!rst_n)
      bit_tick |=> data_out == ($past(data_src_ext) ? $past(ext_bit) : $past(prbs[0])))
      else $error("data out source wrong");
   AST_CLK_OUT: assert property (@(posedge clk) disable iff (!rst_n)
      div_tick |=> data_clk_out != $past(data_clk_out) ##1 $stable(data_clk_out))
      else $error("bit clock out not toggling on divider");
   AST_SYM_WIDTH: assert property (@(posedge clk) disable iff (!rst_n)
      bit_tick && sym_sync_out && !sym_edge |=> !sym_sync_out)
      else $error("symbol sync wider than one bit");
   AST_SYM_STEADY: assert property (@(posedge clk) disable iff (!rst_n)
      !bit_tick |=> $stable(sym_sync_out))
      else $error("symbol sync moved mid bit");
   AST_GATE: assert property (@(posedge clk) disable iff (!rst_n)
      bit_tick && !(gate_en && data_src_ext) |=> data_en_n)
      else $error("gate enabled outside external data mode");
   AST_EVENT: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(event_out) |-> $past(bit_tick)
         && $past(bit_cnt) == $past(event_pos(event_offset, slot_bits, frame_bits)))
      else $error("event pulse at wrong bit");
   AST_AUX: assert property (@(posedge clk) disable iff (!rst_n)
      rt_mode && stb_rise |=> aux_word_valid && aux_word == $past(aux_lvl) ##1 !aux_word_valid)
      else $error("aux word not captured on strobe");
endmodule

// ---- ext_equipment_model.sv ----
// External equipment model driving the link side of the auxiliary port
`timescale 1ns/1ps
module ext_equipment_model
   import aux_port_pkg::*;
(
   // Bit clock and serial lines
   output logic             data_clk_in,
   output logic             data_in,
   output logic             sym_sync_in,
   // Auxiliary word lines
   output logic             aux_strobe,
   output logic [AUX_W-1:0] aux_in
);
   // -------------------------------------------------------------
   // Idle levels
   // -------------------------------------------------------------
   // 320 ns bit period keeps clock and data rate far below the limit
   localparam realtime HALF_NS = 160.0;

   // Clock stands still between frames; data lines fall to pull-up level
   initial begin
      data_clk_in = 1'b0;
      data_in     = 1'b1;
      sym_sync_in = 1'b1;
      aux_strobe  = 1'b0;
      aux_in      = '0;
   end

   // -------------------------------------------------------------
   // Frames
   // -------------------------------------------------------------
   // One trailing period with released lines so the last bit is shown
   task automatic send_bits(input logic [63:0] bits, input logic [63:0] syms, input int n);
      #13;
      for (int k = 0; k <= n; k++) begin
         data_clk_in = 1'b1;
         data_in     = (k < n) ? bits[k] : 1'b1;
         sym_sync_in = (k < n) ? syms[k] : 1'b1;
         #(HALF_NS);
         data_clk_in = 1'b0;
         #(HALF_NS);
      end
   endtask

   // Word settles well before the strobe rises
   task automatic send_aux(input logic [AUX_W-1:0] w);
      #13;
      aux_in = w;
      #400;
      aux_strobe = 1'b1;
      #400;
      aux_strobe = 1'b0;
      #400;
   endtask
endmodule

// ---- aux_serial_data_port_tb_top.sv ----
// Self-checking testbench for the auxiliary serial data port
`timescale 1ns/1ps
module aux_serial_data_port_tb_top
   import aux_port_pkg::*;
;
   // -------------------------------------------------------------
   // Signals
   // -------------------------------------------------------------
   logic clk, rstn, ext_clk_sel, data_src_ext, gate_en, rt_mode, wave_wr_en;
   logic [SYM_W-1:0]       bits_per_sym;
   logic [SLOT_W-1:0]      slot_bits;
   logic [FRAME_W-1:0]     frame_bits;
   logic signed [SLOT_W:0] event_offset;
   logic [MARK_N-1:0]      marker_rt_sel, marker_pol_neg, rt_marker, wave_wr_data, marker_out;
   logic [WAVE_AW-1:0]     wave_wr_addr;
   logic data_clk_in, data_in, sym_sync_in, aux_strobe, aux_word_valid;
   logic data_clk_out, data_out, sym_sync_out, event_out, data_en_n;
   logic [AUX_W-1:0]       aux_in, aux_word;
   int                     miscompares, checks_done, seed_v;
   realtime                t0;

   aux_serial_port dut (.clk(clk), .rstn(rstn), .ext_clk_sel(ext_clk_sel),
      .data_src_ext(data_src_ext), .gate_en(gate_en), .rt_mode(rt_mode),
      .bits_per_sym(bits_per_sym), .slot_bits(slot_bits), .frame_bits(frame_bits),
      .event_offset(event_offset), .marker_rt_sel(marker_rt_sel),
      .marker_pol_neg(marker_pol_neg), .rt_marker(rt_marker), .wave_wr_en(wave_wr_en),
      .wave_wr_addr(wave_wr_addr), .wave_wr_data(wave_wr_data), .data_clk_in(data_clk_in),
      .data_in(data_in), .sym_sync_in(sym_sync_in), .aux_strobe(aux_strobe),
      .aux_in(aux_in), .data_clk_out(data_clk_out), .data_out(data_out),
      .sym_sync_out(sym_sync_out), .event_out(event_out), .data_en_n(data_en_n),
      .marker_out(marker_out), .aux_word(aux_word), .aux_word_valid(aux_word_valid));

   ext_equipment_model ext (.data_clk_in(data_clk_in), .data_in(data_in),
      .sym_sync_in(sym_sync_in), .aux_strobe(aux_strobe), .aux_in(aux_in));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   task automatic cmp_bit(input logic got, input logic exp, input string what);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
      end
   endtask

   task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic do_reset();
      rstn <= 1'b0;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      repeat (8) @(posedge clk);
   endtask

   // Returns just after the edge on which the internal bit clock rises
   task automatic wait_tick();
      logic prev;
      int   n;
      n = 0;
      @(posedge clk);
      #1;
      prev = data_clk_out;
      do begin
         @(posedge clk);
         #1;
         if (data_clk_out === 1'b1 && prev === 1'b0) break;
         prev = data_clk_out;
         n++;
      end while (n < 60);
      cmp_bit(n < 60, 1'b1, "bit clock stalled");
   endtask

   // -------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------
   // Internal timing: frame start, gate, symbol sync, generator, markers
   task automatic run_round();
      int         f, s, o, oc, bps, pos, e0, s0, nt;
      logic       gate, oka, ones;
      logic [3:0] flag, sel, pol, rt;
      logic       ev [128];
      logic       en [128];
      logic       sy [128];
      logic       dq [128];
      f = 20 + $urandom_range(20);
      s = 2 + $urandom_range(6);
      o = int'($urandom_range(2 * s + 4)) - s - 2;
      bps = $urandom_range(8);
      @(posedge clk);
      ext_clk_sel    <= 1'b0;
      data_src_ext   <= 1'($urandom_range(1));
      gate_en        <= 1'($urandom_range(1));
      frame_bits     <= 10'(f);
      slot_bits      <= 8'(s);
      event_offset   <= 9'(o);
      bits_per_sym   <= 4'(bps);
      marker_rt_sel  <= 4'h0;
      marker_pol_neg <= 4'h0;
      do_reset();
      gate = gate_en & data_src_ext;
      oc   = (o > s) ? s : ((o < -s) ? -s : o);
      pos  = (oc >= 0) ? oc : f + oc;
      bps  = (bps == 0) ? 1 : bps;
      nt   = 3 * f;
      for (int j = 0; j < nt; j++) begin
         wait_tick();
         ev[j] = event_out;
         en[j] = data_en_n;
         sy[j] = sym_sync_out;
         dq[j] = data_out;
         sel = (j == 0) ? 4'h0 : 4'($urandom);
         pol = (j == 0) ? 4'h0 : 4'($urandom);
         rt  = 4'($urandom);
         @(posedge clk);
         marker_rt_sel  <= sel;
         marker_pol_neg <= pol;
         rt_marker      <= rt;
         repeat (10) @(posedge clk);
         #1;
         // Play address is one tick ahead of the loop index
         flag = 4'(j + 1);
         cmp_word({12'h000, marker_out}, {12'h000, ((sel & rt) | (~sel & flag)) ^ pol},
                  "marker");
      end
      e0 = -1;
      s0 = -1;
      for (int j = 0; j < nt; j++) begin
         if (e0 < 0 && ev[j] === 1'b1) e0 = j;
         if (s0 < 0 && sy[j] === 1'b1) s0 = j;
      end
      cmp_bit(e0 == pos, 1'b1, "frame start position");
      cmp_bit(s0 >= 0 && s0 <= bps, 1'b1, "no symbol pulse");
      oka  = 1'b1;
      ones = 1'b0;
      for (int j = 0; j < nt; j++) begin
         if (e0 >= 0 && j >= e0) begin
            cmp_bit(ev[j], ((j - e0) % f) == 0, "frame start");
            cmp_bit(en[j], !(gate && ((j - e0 + pos) % f) < s), "data gate");
         end
         if (s0 >= 0 && j >= s0) cmp_bit(sy[j], ((j - s0) % bps) == 0, "symbol sync");
         if (j >= 12) begin
            oka  &= dq[j] === (dq[j - 9] ^ dq[j - 5]);
            ones |= dq[j] === 1'b1;
         end
      end
      if (!data_src_ext) begin
         cmp_bit(ones & oka, 1'b1, "generator sequence");
      end else begin
         cmp_bit(ones, 1'b0, "held received bit");
      end
   endtask

   // External clock and data: bits and symbol marks pass through
   task automatic run_ext();
      logic [63:0] bits, syms;
      int          p, ph, n, hi;
      logic        sh [41];
      n    = 40;
      p    = 3 + $urandom_range(2);
      ph   = $urandom_range(p - 1);
      bits = {$urandom, $urandom};
      bits[5:0] = 6'b011001;
      syms = '0;
      for (int k = 0; k < n; k++) syms[k] = (k % p) == ph;
      @(posedge clk);
      ext_clk_sel  <= 1'b1;
      data_src_ext <= 1'b1;
      bits_per_sym <= 4'h8;
      do_reset();
      fork
         ext.send_bits(bits, syms, n);
         for (int k = 0; k <= n; k++) begin
            @(posedge data_clk_in);
            repeat (7) @(posedge clk);
            #1;
            sh[k] = sym_sync_out;
            if (k > 0) cmp_bit(data_out, bits[k - 1], "received bit");
         end
      join
      hi = 0;
      for (int k = p + 2; k <= n; k++) begin
         hi += (sh[k] === 1'b1);
         cmp_bit(sh[k], sh[k - p], "captured symbol sync");
      end
      cmp_bit(hi > 0, 1'b1, "no captured symbol sync");
   endtask

   // Auxiliary word capture on the strobe, only in real-time mode
   task automatic run_aux(input logic mode, input logic [AUX_W-1:0] w);
      int               nv;
      logic [AUX_W-1:0] got;
      nv  = 0;
      got = '0;
      @(posedge clk);
      rt_mode <= mode;
      fork
         ext.send_aux(w);
         repeat (36) begin
            @(posedge clk);
            #1;
            if (aux_word_valid === 1'b1) begin
               nv++;
               got = aux_word;
            end
         end
      join
      cmp_word(16'(nv), {15'h0000, mode}, "strobe count");
      if (mode) cmp_word(got, w, "aux word");
   endtask

   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin
      seed_v = $urandom(31640);
      miscompares = 0;
      checks_done = 0;
      {rstn, ext_clk_sel, data_src_ext, gate_en, rt_mode, wave_wr_en} = '0;
      {bits_per_sym, slot_bits, frame_bits, event_offset} = '0;
      {marker_rt_sel, marker_pol_neg, rt_marker, wave_wr_data, wave_wr_addr} = '0;
      // Real-time sources until the flag store is loaded, so no unknown reaches the pins
      marker_rt_sel = 4'hf;
      repeat (3) @(posedge clk);
      #1;
      cmp_bit(data_en_n, 1'b1, "gate in reset");
      cmp_bit(data_out | sym_sync_out | event_out | data_clk_out, 1'b0, "outputs in reset");
      do_reset();
      for (int a = 0; a < 256; a++) begin
         @(posedge clk);
         wave_wr_en   <= 1'b1;
         wave_wr_addr <= 8'(a);
         wave_wr_data <= 4'(a);
      end
      @(posedge clk);
      wave_wr_en <= 1'b0;
      wait_tick();
      t0 = $realtime;
      wait_tick();
      cmp_word(16'(int'(($realtime - t0) / 40.0)), 16'(2 * (int'(DIV_HALF) + 1)),
               "bit clock period");
      repeat (6) run_round();
      repeat (2) run_ext();
      run_aux(1'b1, 16'hffff);
      run_aux(1'b0, 16'h5a5a);
      repeat (3) run_aux(1'b1, 16'($urandom));
      end_sim();
   end

   initial begin
      #3_000_000;
      miscompares++;
      $display("Error at %0t: watchdog expired", $time);
      end_sim();
   end
endmodule
